// ==== design/stt_pkg.sv ====
// Shared constants for the setpoint, trigger and trip sequencer
package stt_pkg;

    localparam int LVL_W = 16;
    localparam int PER_W = 20;
    localparam int IDX_W = 7;
    localparam int DAT_W = 32;
    localparam int AW = 8;

    // Register offsets
    localparam logic [7:0] REG_VOLT_IMM = 8'h00;
    localparam logic [7:0] REG_CURR_IMM = 8'h01;
    localparam logic [7:0] REG_VOLT_TRIG = 8'h02;
    localparam logic [7:0] REG_CURR_TRIG = 8'h03;
    localparam logic [7:0] REG_VOLT_TRIP = 8'h04;
    localparam logic [7:0] REG_CURR_TRIP = 8'h05;
    localparam logic [7:0] REG_PERIOD = 8'h06;
    localparam logic [7:0] REG_MEM_SEL = 8'h07;
    localparam logic [7:0] REG_COMMAND = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h09;
    localparam logic [7:0] REG_INT_STAT = 8'h0a;
    localparam logic [7:0] REG_INT_MASK = 8'h0b;
    localparam logic [7:0] REG_ERROR = 8'h0c;
    localparam logic [7:0] REG_LVL_MAX = 8'h10;
    localparam logic [7:0] REG_LVL_MIN = 8'h11;
    localparam logic [7:0] REG_TRIP_MAX = 8'h12;
    localparam logic [7:0] REG_TRIP_MIN = 8'h13;
    localparam logic [7:0] REG_PER_MAX = 8'h14;
    localparam logic [7:0] REG_PER_MIN = 8'h15;

    // Command register bit positions
    localparam int CMD_INIT = 0;
    localparam int CMD_ABORT = 1;
    localparam int CMD_TRIG = 2;
    localparam int CMD_START = 3;
    localparam int CMD_STOP = 4;
    localparam int CMD_PCLR = 5;
    localparam int CMD_ARM_ON = 6;
    localparam int CMD_ARM_OFF = 7;
    localparam int CMD_SAVE = 8;

    // Interrupt status bit positions
    localparam int IRQ_VTRIP = 0;
    localparam int IRQ_CTRIP = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_SEQEND = 3;

    // Error codes
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_RANGE = 4'h1;
    localparam logic [3:0] ERR_NOT_INIT = 4'h2;

    // Programmable ranges and reset values
    localparam logic [15:0] LVL_MAX = 16'hfa00;
    localparam logic [15:0] LVL_MIN = 16'h0000;
    localparam logic [15:0] TRIP_MAX = 16'hffff;
    localparam logic [15:0] TRIP_MIN = 16'h0000;
    localparam logic [15:0] LVL_RESET = 16'h0000;
    localparam logic [15:0] TRIP_RESET = 16'hffff;

    // Dwell codes in 10 ms units; reserved codes are 0, 9998 s and 9999 s
    localparam logic [19:0] PER_STOP = 20'h00000;
    localparam logic [19:0] PER_MIN = 20'h00001;
    localparam logic [19:0] PER_MAX = 20'hf4114;
    localparam logic [19:0] PER_HOME = 20'hf4178;
    localparam logic [19:0] PER_HOLD = 20'hf41dc;
    localparam logic [6:0] MEM_TOP = 7'h63;

    // Dwell tick
    localparam int TICK_MS = 10;
    localparam int CLK_HZ = 10000000;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

endpackage

// ==== design/stt_sync.sv ====
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module stt_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Data
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    logic [W-1:0] stage1_ff;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_ff <= '0;
            syncOut <= '0;
        end else begin
            stage1_ff <= asyncIn;
            syncOut <= stage1_ff;
        end
    end

endmodule

// ==== design/stt_dwell_timer.sv ====
// Dwell countdown in 10 ms ticks
`timescale 1ns/1ps
module stt_dwell_timer #(
    parameter int unsigned CYCLES_PER_TICK = stt_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control
    input wire logic load,
    input wire logic cancel,
    input wire logic [19:0] ticks,
    output logic done
);

    logic [16:0] presc_ff;
    logic [19:0] remain_ff;
    logic active_ff;
    logic tick;

    assign tick = (presc_ff == 17'(CYCLES_PER_TICK - 1));
    assign done = active_ff && tick && (remain_ff == 20'h00001);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            presc_ff <= 17'h00000;
            remain_ff <= 20'h00000;
            active_ff <= 1'b0;
        end else if (load) begin
            presc_ff <= 17'h00000;
            remain_ff <= ticks;
            active_ff <= 1'b1;
        end else if (cancel || done) begin
            active_ff <= 1'b0;
        end else if (active_ff) begin
            presc_ff <= tick ? 17'h00000 : presc_ff + 17'h00001;
            if (tick) begin
                remain_ff <= remain_ff - 20'h00001;
            end
        end
    end

endmodule

// ==== design/stt_sequencer.sv ====
// Setpoint, trigger, trip and auto-sequence command block
// Notes on behaviour
// - Immediate and pending levels; trigger copies pending
// - Pending level survives immediate writes until trigger/abort
// - Triggered writes only while trigger initiated
// - Triggered query falls back to immediate level
// - Max and min readable for every level
// - Voltage over trip disables output, sets flag
// - Current over trip disables output, sets flag
// - Trip cleared only by clear after fault
// - Trip thresholds stored and read back
// - Dwell from 10 ms to 9997 s, three reserved
// - Period code zero stops like stop command
// - Code 9998 jumps to location zero next
// - Code 9999 holds until stop
// - Start skips to next step in a dwell, not in a hold; stop halts
// - Period query reads selected location
// - Each location holds levels, trips, period
// - Past location 99 wraps to 0
`timescale 1ns/1ps
module stt_sequencer #(
    parameter int unsigned CYCLES_PER_TICK = stt_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Remote pins and measurements
    input wire logic trigPin,
    input wire logic startPin,
    input wire logic stopPin,
    input wire logic [15:0] measVolt,
    input wire logic [15:0] measCurr,
    // Output settings
    output logic [15:0] voltSetpoint,
    output logic [15:0] currSetpoint,
    output logic [15:0] voltTripLevel,
    output logic [15:0] currTripLevel,
    output logic outputOn,
    output logic [6:0] memIndex,
    output logic irq
);

    typedef enum logic [2:0] {SQ_IDLE, SQ_ON, SQ_DWELL, SQ_HOLD, SQ_WRAP} stt_state_t;

    function automatic logic inRange(input logic [31:0] v, input logic [19:0] lo,
                                     input logic [19:0] hi);
        inRange = (v >= {12'h000, lo}) && (v <= {12'h000, hi});
    endfunction

    function automatic logic [6:0] nextIdx(input logic [6:0] i);
        nextIdx = (i == stt_pkg::MEM_TOP) ? 7'h00 : i + 7'h01;
    endfunction

    stt_state_t state_ff;
    stt_state_t nxtState;
    logic [6:0] memSel_ff;
    logic [6:0] nxtSel;
    logic outputOn_ff;
    logic nxtOn;
    logic doLoad;
    logic [6:0] loadIdx;
    logic dwellStart;
    logic seqEnd;
    logic [19:0] code;
    logic dwellDone;

    logic [15:0] voltImm_ff, currImm_ff, voltPend_ff, currPend_ff;
    logic pendV_ff, pendI_ff;
    logic [15:0] voltTrip_ff, currTrip_ff;
    logic initiated_ff, armed_ff;
    logic vTrip_ff, cTrip_ff;
    logic [3:0] errCode_ff;
    logic [3:0] intStat_ff, intMask_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rdMux;

    logic [15:0] memV [0:99];
    logic [15:0] memI [0:99];
    logic [15:0] memVT [0:99];
    logic [15:0] memIT [0:99];
    logic [19:0] memPer [0:99];

    logic [2:0] pinSync;
    logic [2:0] pinPrev_ff;
    logic [2:0] pinRise;
    logic [15:0] measVoltS, measCurrS;

    stt_sync #(.W(3)) u_pinSync (
        .mclk(mclk),
        .reset_n(reset_n),
        .asyncIn({stopPin, startPin, trigPin}),
        .syncOut(pinSync)
    );

    // Measurements come from a converter on another clock; words may tear for one cycle
    stt_sync #(.W(32)) u_measSync (
        .mclk(mclk),
        .reset_n(reset_n),
        .asyncIn({measCurr, measVolt}),
        .syncOut({measCurrS, measVoltS})
    );

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pinPrev_ff <= 3'h0;
        end else begin
            pinPrev_ff <= pinSync;
        end
    end
    assign pinRise = pinSync & ~pinPrev_ff;

    logic cmdWr, trigEv, startEv, stopEv, abortEv, initEv, pclrEv, saveEv;
    logic vOver, cOver, tripAny;
    logic wrVImm, wrIImm, wrVTrg, wrITrg, wrVTrip, wrITrip, wrPer, wrSel;
    logic rangeErr, initErr;

    assign cmdWr = regWr && (regAddr == stt_pkg::REG_COMMAND);
    assign trigEv = (cmdWr && regWdata[stt_pkg::CMD_TRIG]) || pinRise[0];
    assign startEv = (cmdWr && regWdata[stt_pkg::CMD_START]) || pinRise[1];
    assign stopEv = (cmdWr && regWdata[stt_pkg::CMD_STOP]) || pinRise[2];
    assign abortEv = cmdWr && regWdata[stt_pkg::CMD_ABORT];
    assign initEv = cmdWr && regWdata[stt_pkg::CMD_INIT];
    assign pclrEv = cmdWr && regWdata[stt_pkg::CMD_PCLR];
    assign saveEv = cmdWr && regWdata[stt_pkg::CMD_SAVE];

    assign vOver = measVoltS > voltTrip_ff;
    assign cOver = measCurrS > currTrip_ff;
    assign tripAny = vOver || cOver || vTrip_ff || cTrip_ff;

    // Writes that pass the range check
    assign wrVImm = regWr && (regAddr == stt_pkg::REG_VOLT_IMM) &&
                    inRange(regWdata, 20'(stt_pkg::LVL_MIN), 20'(stt_pkg::LVL_MAX));
    assign wrIImm = regWr && (regAddr == stt_pkg::REG_CURR_IMM) &&
                    inRange(regWdata, 20'(stt_pkg::LVL_MIN), 20'(stt_pkg::LVL_MAX));
    assign wrVTrg = regWr && (regAddr == stt_pkg::REG_VOLT_TRIG) &&
                    inRange(regWdata, 20'(stt_pkg::LVL_MIN), 20'(stt_pkg::LVL_MAX));
    assign wrITrg = regWr && (regAddr == stt_pkg::REG_CURR_TRIG) &&
                    inRange(regWdata, 20'(stt_pkg::LVL_MIN), 20'(stt_pkg::LVL_MAX));
    assign wrVTrip = regWr && (regAddr == stt_pkg::REG_VOLT_TRIP) &&
                     inRange(regWdata, 20'(stt_pkg::TRIP_MIN), 20'(stt_pkg::TRIP_MAX));
    assign wrITrip = regWr && (regAddr == stt_pkg::REG_CURR_TRIP) &&
                     inRange(regWdata, 20'(stt_pkg::TRIP_MIN), 20'(stt_pkg::TRIP_MAX));
    assign wrPer = regWr && (regAddr == stt_pkg::REG_PERIOD) &&
                   (inRange(regWdata, stt_pkg::PER_MIN, stt_pkg::PER_MAX) ||
                    regWdata == {12'h000, stt_pkg::PER_STOP} ||
                    regWdata == {12'h000, stt_pkg::PER_HOME} ||
                    regWdata == {12'h000, stt_pkg::PER_HOLD});
    assign wrSel = regWr && (regAddr == stt_pkg::REG_MEM_SEL) &&
                   inRange(regWdata, 20'h00000, 20'(stt_pkg::MEM_TOP));

    // A rejected value leaves the stored one alone
    assign rangeErr = regWr && !wrVImm && !wrIImm && !wrVTrg && !wrITrg && !wrVTrip &&
                      !wrITrip && !wrPer && !wrSel &&
                      ((regAddr <= stt_pkg::REG_MEM_SEL));
    assign initErr = !initiated_ff && (wrVTrg || wrITrg);

    // Sequencer next state
    always_comb begin
        nxtState = state_ff;
        nxtSel = wrSel ? regWdata[6:0] : memSel_ff;
        nxtOn = outputOn_ff;
        doLoad = 1'b0;
        loadIdx = memSel_ff;
        dwellStart = 1'b0;
        seqEnd = 1'b0;
        code = 20'h00000;
        if (tripAny) begin
            nxtState = SQ_IDLE;
            nxtOn = 1'b0;
        end else begin
            case (state_ff)
                SQ_IDLE: begin
                    if (startEv && !stopEv) begin
                        if (armed_ff) begin
                            doLoad = 1'b1;
                            loadIdx = nxtSel;
                        end else begin
                            nxtState = SQ_ON;
                            nxtOn = 1'b1;
                        end
                    end
                end
                SQ_ON, SQ_HOLD: begin
                    if (stopEv) begin
                        nxtState = SQ_IDLE;
                        nxtOn = 1'b0;
                    end
                end
                SQ_DWELL: begin
                    if (stopEv) begin
                        nxtState = SQ_IDLE;
                        nxtOn = 1'b0;
                    end else if (startEv || dwellDone) begin
                        doLoad = 1'b1;
                        loadIdx = nextIdx(memSel_ff);
                    end
                end
                SQ_WRAP: begin
                    if (stopEv) begin
                        nxtState = SQ_IDLE;
                        nxtOn = 1'b0;
                    end else begin
                        doLoad = 1'b1;
                        loadIdx = 7'h00;
                    end
                end
                default: begin
                    nxtState = SQ_IDLE;
                    nxtOn = 1'b0;
                end
            endcase
        end
        if (doLoad) begin
            code = memPer[loadIdx];
            nxtSel = loadIdx;
            nxtOn = 1'b1;
            if (code == stt_pkg::PER_STOP) begin
                nxtState = SQ_IDLE;
                nxtOn = 1'b0;
                seqEnd = 1'b1;
            end else if (code == stt_pkg::PER_HOME) begin
                nxtState = SQ_WRAP;
            end else if (code == stt_pkg::PER_HOLD) begin
                nxtState = SQ_HOLD;
            end else begin
                nxtState = SQ_DWELL;
                dwellStart = 1'b1;
            end
        end
    end

    stt_dwell_timer #(.CYCLES_PER_TICK(CYCLES_PER_TICK)) u_dwell (
        .mclk(mclk),
        .reset_n(reset_n),
        .load(dwellStart),
        .cancel(state_ff != SQ_DWELL),
        .ticks(code),
        .done(dwellDone)
    );

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= SQ_IDLE;
            memSel_ff <= 7'h00;
            outputOn_ff <= 1'b0;
        end else begin
            state_ff <= nxtState;
            memSel_ff <= nxtSel;
            outputOn_ff <= nxtOn;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            armed_ff <= 1'b0;
            initiated_ff <= 1'b0;
        end else begin
            if (cmdWr && regWdata[stt_pkg::CMD_ARM_ON]) begin
                armed_ff <= 1'b1;
            end else if (cmdWr && regWdata[stt_pkg::CMD_ARM_OFF]) begin
                armed_ff <= 1'b0;
            end
            if (abortEv || (trigEv && initiated_ff)) begin
                initiated_ff <= 1'b0;
            end else if (initEv) begin
                initiated_ff <= 1'b1;
            end
        end
    end

    // Levels: bus writes, trigger transfer, then step load takes priority
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            voltImm_ff <= stt_pkg::LVL_RESET;
            currImm_ff <= stt_pkg::LVL_RESET;
            voltPend_ff <= stt_pkg::LVL_RESET;
            currPend_ff <= stt_pkg::LVL_RESET;
            pendV_ff <= 1'b0;
            pendI_ff <= 1'b0;
            voltTrip_ff <= stt_pkg::TRIP_RESET;
            currTrip_ff <= stt_pkg::TRIP_RESET;
        end else begin
            if (wrVImm) begin
                voltImm_ff <= regWdata[15:0];
            end
            if (wrIImm) begin
                currImm_ff <= regWdata[15:0];
            end
            if (wrVTrip) begin
                voltTrip_ff <= regWdata[15:0];
            end
            if (wrITrip) begin
                currTrip_ff <= regWdata[15:0];
            end
            if (wrVTrg && initiated_ff) begin
                voltPend_ff <= regWdata[15:0];
                pendV_ff <= 1'b1;
            end
            if (wrITrg && initiated_ff) begin
                currPend_ff <= regWdata[15:0];
                pendI_ff <= 1'b1;
            end
            if (trigEv && initiated_ff) begin
                if (pendV_ff) begin
                    voltImm_ff <= voltPend_ff;
                end
                if (pendI_ff) begin
                    currImm_ff <= currPend_ff;
                end
            end
            if (abortEv || (trigEv && initiated_ff)) begin
                pendV_ff <= 1'b0;
                pendI_ff <= 1'b0;
            end
            if (doLoad) begin
                voltImm_ff <= memV[loadIdx];
                currImm_ff <= memI[loadIdx];
                voltTrip_ff <= memVT[loadIdx];
                currTrip_ff <= memIT[loadIdx];
            end
        end
    end

    // Sequence memory
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int k = 0; k < 100; k++) begin
                memV[k] <= stt_pkg::LVL_RESET;
                memI[k] <= stt_pkg::LVL_RESET;
                memVT[k] <= stt_pkg::TRIP_RESET;
                memIT[k] <= stt_pkg::TRIP_RESET;
                memPer[k] <= stt_pkg::PER_STOP;
            end
        end else begin
            if (saveEv) begin
                memV[memSel_ff] <= voltImm_ff;
                memI[memSel_ff] <= currImm_ff;
                memVT[memSel_ff] <= voltTrip_ff;
                memIT[memSel_ff] <= currTrip_ff;
            end
            if (wrPer) begin
                memPer[memSel_ff] <= regWdata[19:0];
            end
        end
    end

    // Trip latches; a new fault beats a clear in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            vTrip_ff <= 1'b0;
            cTrip_ff <= 1'b0;
        end else begin
            vTrip_ff <= vOver || (vTrip_ff && !pclrEv);
            cTrip_ff <= cOver || (cTrip_ff && !pclrEv);
        end
    end

    // Error code and interrupts; hardware set wins over software clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            errCode_ff <= stt_pkg::ERR_NONE;
            intStat_ff <= 4'h0;
            intMask_ff <= 4'h0;
        end else begin
            if (rangeErr) begin
                errCode_ff <= stt_pkg::ERR_RANGE;
            end else if (initErr) begin
                errCode_ff <= stt_pkg::ERR_NOT_INIT;
            end else if (regRd && regAddr == stt_pkg::REG_ERROR) begin
                errCode_ff <= stt_pkg::ERR_NONE;
            end
            if (regWr && regAddr == stt_pkg::REG_INT_MASK) begin
                intMask_ff <= regWdata[3:0];
            end
            intStat_ff <= (intStat_ff &
                           ~((regWr && regAddr == stt_pkg::REG_INT_STAT) ? regWdata[3:0] : 4'h0))
                          | {seqEnd, rangeErr || initErr, cOver && !cTrip_ff, vOver && !vTrip_ff};
        end
    end

    // Read mux
    always_comb begin
        rdMux = 32'h00000000;
        if (regAddr == stt_pkg::REG_VOLT_IMM) begin
            rdMux = {16'h0000, voltImm_ff};
        end else if (regAddr == stt_pkg::REG_CURR_IMM) begin
            rdMux = {16'h0000, currImm_ff};
        end else if (regAddr == stt_pkg::REG_VOLT_TRIG) begin
            rdMux = {16'h0000, pendV_ff ? voltPend_ff : voltImm_ff};
        end else if (regAddr == stt_pkg::REG_CURR_TRIG) begin
            rdMux = {16'h0000, pendI_ff ? currPend_ff : currImm_ff};
        end else if (regAddr == stt_pkg::REG_VOLT_TRIP) begin
            rdMux = {16'h0000, voltTrip_ff};
        end else if (regAddr == stt_pkg::REG_CURR_TRIP) begin
            rdMux = {16'h0000, currTrip_ff};
        end else if (regAddr == stt_pkg::REG_PERIOD) begin
            rdMux = {12'h000, memPer[memSel_ff]};
        end else if (regAddr == stt_pkg::REG_MEM_SEL) begin
            rdMux = {25'h0000000, memSel_ff};
        end else if (regAddr == stt_pkg::REG_STATUS) begin
            rdMux = {22'h000000, state_ff, initiated_ff, armed_ff, outputOn_ff,
                     2'h0, cTrip_ff, vTrip_ff};
        end else if (regAddr == stt_pkg::REG_INT_STAT) begin
            rdMux = {28'h0000000, intStat_ff};
        end else if (regAddr == stt_pkg::REG_INT_MASK) begin
            rdMux = {28'h0000000, intMask_ff};
        end else if (regAddr == stt_pkg::REG_ERROR) begin
            rdMux = {28'h0000000, errCode_ff};
        end else if (regAddr == stt_pkg::REG_LVL_MAX) begin
            rdMux = {16'h0000, stt_pkg::LVL_MAX};
        end else if (regAddr == stt_pkg::REG_LVL_MIN) begin
            rdMux = {16'h0000, stt_pkg::LVL_MIN};
        end else if (regAddr == stt_pkg::REG_TRIP_MAX) begin
            rdMux = {16'h0000, stt_pkg::TRIP_MAX};
        end else if (regAddr == stt_pkg::REG_TRIP_MIN) begin
            rdMux = {16'h0000, stt_pkg::TRIP_MIN};
        end else if (regAddr == stt_pkg::REG_PER_MAX) begin
            rdMux = {12'h000, stt_pkg::PER_MAX};
        end else if (regAddr == stt_pkg::REG_PER_MIN) begin
            rdMux = {12'h000, stt_pkg::PER_MIN};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= regRd ? rdMux : 32'h00000000;
        end
    end

    assign regRdata = rdata_ff;
    assign voltSetpoint = voltImm_ff;
    assign currSetpoint = currImm_ff;
    assign voltTripLevel = voltTrip_ff;
    assign currTripLevel = currTrip_ff;
    assign outputOn = outputOn_ff;
    assign memIndex = memSel_ff;
    assign irq = |(intStat_ff & intMask_ff);

endmodule

// ==== tb/stt_sequencer_props.sv ====
// Port checker for the sequencer
`timescale 1ns/1ps
module stt_sequencer_props (
    // Clock, reset, bus
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // Pins and settings
    input wire logic stopPin,
    input wire logic [15:0] measVolt,
    input wire logic [15:0] measCurr,
    input wire logic [15:0] voltSetpoint,
    input wire logic [15:0] voltTripLevel,
    input wire logic [15:0] currTripLevel,
    input wire logic outputOn,
    input wire logic [6:0] memIndex
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_rdata_one_cycle: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside its cycle");
    a_volt_trip_off: assert property ((measVolt > voltTripLevel) [*3] |-> ##[0:2] !outputOn)
        else $error("output kept on above voltage trip");
    a_curr_trip_off: assert property ((measCurr > currTripLevel) [*3] |-> ##[0:2] !outputOn)
        else $error("output kept on above current trip");
    a_imm_write_takes: assert property (regWr && regAddr == 8'h00 && regWdata <= 32'hfa00
        |=> {16'h0, voltSetpoint} == $past(regWdata))
        else $error("immediate level not taken");
    a_range_reject: assert property (regWr && regAddr == 8'h00 && regWdata > 32'hfa00
        |=> $stable(voltSetpoint))
        else $error("out of range level taken");
    a_trip_stored: assert property (regWr && regAddr == 8'h05 && regWdata < 32'h10000
        |=> {16'h0, currTripLevel} == $past(regWdata))
        else $error("trip level not stored");
    a_mem_select: assert property (regWr && regAddr == 8'h07 && regWdata < 32'h64
        |=> {25'h0, memIndex} == $past(regWdata))
        else $error("memory location not selected");
    a_stop_halts: assert property ($rose(stopPin) |-> ##[1:4] !outputOn)
        else $error("stop did not halt");
endmodule
bind stt_sequencer stt_sequencer_props stt_sequencer_props_inst (.*);

// ==== tb/stt_host_model.sv ====
// Host side model issuing register commands
`timescale 1ns/1ps
module stt_host_model (
    // Clock and register port
    input wire logic mclk,
    output logic [7:0] regAddr = 8'h00,
    output logic [31:0] regWdata = 32'h0,
    output logic regWr = 1'b0,
    output logic regRd = 1'b0,
    input wire logic [31:0] regRdata
);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    // Data sampled mid-cycle, after the registered answer settles
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        d = regRdata;
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module testbench;
    logic mclk, reset_n, regWr, regRd, trigPin, startPin, stopPin, outputOn, irq;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, v, e;
    logic [15:0] measVolt, measCurr, voltSetpoint, currSetpoint, voltTripLevel, currTripLevel;
    logic [6:0] memIndex;
    logic [31:0] lim [6] = '{32'hfa00, 32'h0, 32'hffff, 32'h0, 32'hf4114, 32'h1};
    int fails, total_checks, i;
    int seed = 40;
    stt_sequencer #(.CYCLES_PER_TICK(4)) stt_sequencer_inst (.*);
    stt_host_model host (.*);
    task chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] d;
        host.rd(a, d);
        chk(d, x);
    endtask
    task wt(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task meas(input logic [15:0] m);
        @(posedge mclk);
        if (i == 1) measCurr <= m; else measVolt <= m;
        wt(5);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        #400000;
        fails++;
        complete_run;
    end
    initial begin
        {reset_n, trigPin, startPin, stopPin, measVolt, measCurr} = 36'h0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        e = 32'h0;
        for (i = 0; i < 8; i++) begin
            v = i[2:1] ? $random(seed) & 32'h1ffff : 32'hfa00 + i;
            host.wr(8'h00, v);
            if (v <= 32'hfa00) e = v;
            rchk(8'h00, e);
        end
        rchk(8'h0c, 32'h1);
        $display("done: immediate levels");
        host.wr(8'h02, 32'h1234);
        rchk(8'h0c, 32'h2);
        rchk(8'h02, e);
        host.wr(8'h08, 32'h1);
        host.wr(8'h02, 32'h1234);
        host.wr(8'h00, 32'h42);
        rchk(8'h02, 32'h1234);
        host.wr(8'h08, 32'h4);
        rchk(8'h00, 32'h1234);
        host.wr(8'h08, 32'h1);
        host.wr(8'h03, 32'h77);
        host.wr(8'h08, 32'h2);
        rchk(8'h03, 32'h0);
        for (i = 0; i < 6; i++) rchk(8'h10 + 8'(i), lim[i]);
        $display("done: triggered levels");
        host.wr(8'h0b, 32'h3);
        for (i = 0; i < 2; i++) begin
            host.wr(8'h04 + 8'(i), 32'h800);
            rchk(8'h04 + 8'(i), 32'h800);
            host.wr(8'h08, 32'h8);
            meas(16'h800);
            chk({31'h0, outputOn}, 32'h1);
            meas(16'h801);
            chk({30'h0, outputOn, irq}, 32'h1);
            host.wr(8'h08, 32'h20);
            rchk(8'h09, 32'h1 << i);
            host.wr(8'h0b, 32'h0);
            wt(0);
            chk({31'h0, irq}, 32'h0);
            host.wr(8'h0b, 32'h3);
            meas(16'h0);
            host.wr(8'h08, 32'h20);
            rchk(8'h09, 32'h0);
            chk({31'h0, irq}, 32'h1);
            host.wr(8'h0a, 32'h3);
            wt(0);
            chk({31'h0, irq}, 32'h0);
        end
        $display("done: protection");
        host.wr(8'h08, 32'h40);
        host.wr(8'h07, 32'h0);
        host.wr(8'h06, 32'hf41dc);
        host.wr(8'h07, 32'h63);
        host.wr(8'h06, 32'hf4114);
        rchk(8'h06, 32'hf4114);
        host.wr(8'h08, 32'h8);
        wt(0);
        chk({24'h0, outputOn, memIndex}, 32'he3);
        @(posedge mclk) startPin <= 1'b1;
        wt(5);
        chk({24'h0, outputOn, memIndex}, 32'h80);
        wt(20);
        chk({24'h0, outputOn, memIndex}, 32'h80);
        @(posedge mclk) stopPin <= 1'b1;
        wt(5);
        chk({31'h0, outputOn}, 32'h0);
        {startPin, stopPin} <= 2'b00;
        host.wr(8'h07, 32'h62);
        host.wr(8'h06, 32'hf4178);
        host.wr(8'h08, 32'h8);
        wt(3);
        chk({24'h0, outputOn, memIndex}, 32'h80);
        host.wr(8'h08, 32'h10);
        host.wr(8'h07, 32'h0);
        host.wr(8'h06, 32'h2);
        host.wr(8'h08, 32'h8);
        wt(9);
        rchk(8'h0a, 32'hc);
        chk({currSetpoint, 15'h0, outputOn}, 32'h0);
        $display("done: sequencing");
        complete_run;
    end
endmodule
